// ===== rtl/eivm_top.sv
// eivm_top.sv: external interrupt detection and vector address map, AHB-Lite slave
// assumes: single AHB-Lite master, word accesses, core requests vectors with vec_req
`timescale 1ns/100ps
`include "eivm_regs.svh"

module eivm_top
  import eivm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_irq_pin,
  input wire logic [7:0] pin_change_inputs_group_a,
  input wire logic [3:0] pin_change_inputs_group_b,
  input wire logic [5:0] pin_change_inputs_group_c,
  input wire logic [22:0] periph_irq,
  input wire logic sleep_deep,
  input wire logic vec_req,
  output logic irq_pending,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  output logic [4:0] vec_num,
  output logic io_clk_run,
  output logic wake_event,
  output logic [15:0] reset_vec_addr
);
  logic [7:0] ctrl;
  logic [7:0] pin_change_mask_a;
  logic [3:0] pin_change_mask_b;
  logic [5:0] pin_change_mask_c;
  logic [7:0] enable;
  logic [3:0] flags;
  logic ext_s1, ext_s2, ext_prev;
  logic [17:0] pc_s1, pc_s2;
  logic pca_hit, pcb_hit, pcc_hit;
  logic ph_wr, ph_rd;
  logic [11:0] ph_addr;
  logic wr_flags;
  logic [3:0] flag_set, flag_clr;
  logic ext_edge;
  logic [27:0] req;
  logic [4:0] next_vec_num;
  logic next_valid;
  eivm_sense_t sense;
  eivm_ack_t ack_state;

  function automatic logic [15:0] eivm_vec_of(input logic [4:0] n);
    // vector n (1-based) sits at (n-1) * 2 words
    eivm_vec_of = `EIVM_VEC_RESET + 16'({11'h000, n - 5'd1} * `EIVM_VEC_STEP);
  endfunction

  assign sense = eivm_sense_t'(ctrl[`EIVM_CTRL_SENSE_LO +: 2]);
  assign reset_vec_addr = `EIVM_VEC_RESET;
  assign io_clk_run = !sleep_deep;

  // two flops per input; pins read whether driven out or
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_prev <= 1'b1;
      pc_s1 <= '0;
      pc_s2 <= '0;
    end else begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
      pc_s1 <= {pin_change_inputs_group_c, pin_change_inputs_group_b, pin_change_inputs_group_a};
      pc_s2 <= pc_s1;
    end
  end

  eivm_pin_change #(.WIDTH(8)) u_pca (
    .hclk(hclk), .hresetn(hresetn), .pins(pc_s2[7:0]), .mask(pin_change_mask_a), .hit(pca_hit));
  eivm_pin_change #(.WIDTH(4)) u_pcb (
    .hclk(hclk), .hresetn(hresetn), .pins(pc_s2[11:8]), .mask(pin_change_mask_b), .hit(pcb_hit));
  eivm_pin_change #(.WIDTH(6)) u_pcc (
    .hclk(hclk), .hresetn(hresetn), .pins(pc_s2[17:12]), .mask(pin_change_mask_c), .hit(pcc_hit));

  // async wake paths: combinational, work with hclk stopped
  // raw pins against the synced copy, so a change shows before hclk is back
  assign wake_event = (!ext_irq_pin && sense == eivm_sense_low && enable[`EIVM_EN_EXT])
    || (|({pin_change_inputs_group_c, pin_change_inputs_group_b, pin_change_inputs_group_a}
          ^ pc_s2));

  // edges need the clocked sampler
  always_comb begin
    unique case (sense)
      eivm_sense_low: ext_edge = 1'b0;
      eivm_sense_any: ext_edge = ext_s2 ^ ext_prev;
      eivm_sense_fall: ext_edge = ext_prev && !ext_s2;
      eivm_sense_rise: ext_edge = !ext_prev && ext_s2;
    endcase
  end

  // bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= '0;
    end else if (hready) begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_rd <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr[11:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `EIVM_RESET_VAL;
      pin_change_mask_a <= '0;
      pin_change_mask_b <= '0;
      pin_change_mask_c <= '0;
      enable <= `EIVM_RESET_VAL;
    end else if (ph_wr) begin
      unique case (ph_addr)
        `EIVM_OFS_CTRL: ctrl <= {5'h00, hwdata[2:0]};
        `EIVM_OFS_MASK_A: pin_change_mask_a <= hwdata[7:0];
        `EIVM_OFS_MASK_B: pin_change_mask_b <= hwdata[3:0];
        `EIVM_OFS_MASK_C: pin_change_mask_c <= hwdata[5:0];
        `EIVM_OFS_ENABLE: enable <= {1'b0, hwdata[6:3], 3'h0};
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (hready) begin
      unique case (haddr[11:0])
        `EIVM_OFS_CTRL: hrdata <= {24'h0, ctrl};
        `EIVM_OFS_MASK_A: hrdata <= {24'h0, pin_change_mask_a};
        `EIVM_OFS_MASK_B: hrdata <= {28'h0, pin_change_mask_b};
        `EIVM_OFS_MASK_C: hrdata <= {26'h0, pin_change_mask_c};
        `EIVM_OFS_ENABLE: hrdata <= {24'h0, enable};
        `EIVM_OFS_FLAGS: hrdata <= {25'h0, flags, 3'h0};
        `EIVM_OFS_STATUS: hrdata <= {27'h0, vec_num};
        default: hrdata <= '0;
      endcase
    end
  end

  // flags: bit3 ext, bits 0..2 groups a..c; set beats clear
  assign wr_flags = ph_wr && ph_addr == `EIVM_OFS_FLAGS;
  assign flag_set = {ext_edge, pcc_hit, pcb_hit, pca_hit};
  always_comb begin
    flag_clr = wr_flags ? {hwdata[6], hwdata[5:3]} : 4'h0;
    if (ack_state == eivm_ack_idle && vec_req && vec_valid) begin
      unique case (vec_num)
        5'd2: flag_clr[3] = 1'b1;
        5'd3: flag_clr[0] = 1'b1;
        5'd4: flag_clr[1] = 1'b1;
        5'd5: flag_clr[2] = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= 4'h0;
    end else begin
      // level mode keeps the flag clear, request comes from the pin itself
      flags <= ((flags & ~flag_clr) | flag_set) & {sense != eivm_sense_low, 3'h7};
    end
  end

  // level-mode ext request only while the synchronised level is still low
  always_comb begin
    req = '0;
    req[1] = (sense == eivm_sense_low ? !ext_s2 : flags[3]) && enable[`EIVM_EN_EXT];
    req[2] = flags[0] && enable[`EIVM_EN_PCA];
    req[3] = flags[1] && enable[`EIVM_EN_PCB];
    req[4] = flags[2] && enable[`EIVM_EN_PCC];
    req[27:5] = periph_irq;
    req = ctrl[`EIVM_CTRL_GIE] ? req : '0;
  end

  always_comb begin
    next_vec_num = 5'd0;
    next_valid = 1'b0;
    for (int i = 27; i >= 1; i--) begin
      if (req[i]) begin
        next_vec_num = 5'(i + 1);
        next_valid = 1'b1;
      end
    end
  end

  // vec_num and vec_addr held while the core holds vec_req; vec_valid drops after the take
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_state <= eivm_ack_idle;
      vec_num <= 5'd0;
      vec_valid <= 1'b0;
      vec_addr <= `EIVM_VEC_RESET;
    end else begin
      unique case (ack_state)
        eivm_ack_idle: begin
          if (vec_req && vec_valid) begin
            ack_state <= eivm_ack_hold;
          end else begin
            vec_num <= next_vec_num;
            vec_valid <= next_valid;
            vec_addr <= next_valid ? eivm_vec_of(next_vec_num) : `EIVM_VEC_RESET;
          end
        end
        eivm_ack_hold: begin
          vec_valid <= 1'b0;
          if (!vec_req) begin
            ack_state <= eivm_ack_idle;
          end
        end
        default: ack_state <= eivm_ack_idle;
      endcase
    end
  end

  assign irq_pending = |req;

  chk_ext_vector_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd2 |-> vec_addr == `EIVM_VEC_EXT) else $error("ext vector wrong");
  chk_group_vectors: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd5 |-> vec_addr == `EIVM_VEC_PCC) else $error("group c vector wrong");
  chk_last_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd28 |-> vec_addr == `EIVM_VEC_LAST) else $error("last vector wrong");
  chk_no_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[`EIVM_CTRL_GIE] && $past(!ctrl[`EIVM_CTRL_GIE]) && ack_state == eivm_ack_idle
    |=> !vec_valid) else $error("vector offered while disabled");
  chk_fall_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    sense == eivm_sense_fall && ext_prev && !ext_s2 |=> flags[3]) else $error("fall missed");
  chk_level_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl[2:0] == 3'b100 && enable[`EIVM_EN_EXT] && !ext_s2 |-> irq_pending)
    else $error("low level not requesting");
  chk_group_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable[`EIVM_EN_PCA] |-> !req[2]) else $error("group a requested while disabled");
  chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    pca_hit |=> flags[0]) else $error("group a change lost");
  chk_priority_low: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_state == eivm_ack_idle && !vec_req && req[1] |=> vec_num == 5'd2)
    else $error("lower vector not first");
  // map, gating, flag housekeeping, wake and grant hold
  chk_reset_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_vec_addr == `EIVM_VEC_RESET) else $error("reset vector moved");
  chk_group_a_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd3 |-> vec_addr == `EIVM_VEC_PCA) else $error("group a vector wrong");
  chk_group_b_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd4 |-> vec_addr == `EIVM_VEC_PCB) else $error("group b vector wrong");
  chk_wdt_vector: assert property (@(posedge hclk) disable iff (!hresetn)
    vec_valid && vec_num == 5'd6 |-> vec_addr == `EIVM_VEC_WDT) else $error("first periph vector wrong");
  chk_clk_halted: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_deep |-> !io_clk_run) else $error("io clock runs in deep sleep");
  chk_gie_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl[`EIVM_CTRL_GIE] |-> !irq_pending) else $error("request with global enable off");
  chk_level_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    sense == eivm_sense_low |=> !flags[3]) else $error("ext flag set in level mode");
  chk_take_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_state == eivm_ack_idle && vec_req && vec_valid && vec_num == 5'd3 && !pca_hit
    |=> !flags[0]) else $error("group a flag kept after take");
  chk_pc_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    |({pin_change_inputs_group_c, pin_change_inputs_group_b,
       pin_change_inputs_group_a} ^ pc_s2) |-> wake_event) else $error("pin change gave no wake");
  chk_hold_drops_valid: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_state == eivm_ack_hold |=> !vec_valid) else $error("grant offered twice");
endmodule

// ===== rtl/eivm_regs.svh
// eivm_regs.svh: register offsets, field positions, reset values and vector addresses
// assumes: included by bare name into the vector map design files
`ifndef EIVM_REGS_SVH
`define EIVM_REGS_SVH

`define EIVM_OFS_CTRL 12'h000
`define EIVM_OFS_MASK_A 12'h004
`define EIVM_OFS_MASK_B 12'h008
`define EIVM_OFS_MASK_C 12'h00c
`define EIVM_OFS_ENABLE 12'h010
`define EIVM_OFS_FLAGS 12'h014
`define EIVM_OFS_STATUS 12'h018

`define EIVM_CTRL_SENSE_LO 0
`define EIVM_CTRL_GIE 2
`define EIVM_EN_EXT 6
`define EIVM_EN_PCA 3
`define EIVM_EN_PCB 4
`define EIVM_EN_PCC 5
`define EIVM_RESET_VAL 8'h00

`define EIVM_VEC_RESET 16'h0000
`define EIVM_VEC_EXT 16'h0002
`define EIVM_VEC_PCA 16'h0004
`define EIVM_VEC_PCB 16'h0006
`define EIVM_VEC_PCC 16'h0008
`define EIVM_VEC_WDT 16'h000a
`define EIVM_VEC_LAST 16'h0036
`define EIVM_VEC_COUNT 28
`define EIVM_VEC_STEP 16'h0002

`endif

// ===== rtl/eivm_pkg.sv
// eivm_pkg.sv: types shared by the vector map design files
// assumes: nothing beyond a SystemVerilog compiler
package eivm_pkg;
  typedef enum logic [1:0] {
    eivm_sense_low = 2'b00,
    eivm_sense_any = 2'b01,
    eivm_sense_fall = 2'b10,
    eivm_sense_rise = 2'b11
  } eivm_sense_t;
  typedef enum logic [1:0] {
    eivm_ack_idle = 2'b00,
    eivm_ack_hold = 2'b01
  } eivm_ack_t;
endpackage

// ===== rtl/eivm_pin_change.sv
// eivm_pin_change.sv: change detector for one group of pin-change inputs
// assumes: pins already synchronised to hclk by the caller
`timescale 1ns/100ps
module eivm_pin_change
  import eivm_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] mask,
  output logic hit
);
  logic [WIDTH-1:0] prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= '0;
    end else begin
      prev <= pins;
    end
  end

  // a masked-off pin never contributes
  assign hit = |((pins ^ prev) & mask);

  chk_masked_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (mask == '0) |-> !hit) else $error("unmasked group reported a change");
endmodule

// ===== tb/eivm_core_model.sv
// eivm_core_model.sv: processor core side that takes granted vectors
// assumes: eivm_top grant outputs, rising edge of hclk, active low reset
`timescale 1ns/100ps
module eivm_core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic vec_valid,
  output logic vec_req,
  output int takes
);
  logic [1:0] stall;
  // random stall so some grants wait on a slow core
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_req <= 1'b0;
      stall <= 2'd0;
      takes <= 0;
    end else if (vec_req && vec_valid) begin
      vec_req <= 1'b0;
      stall <= 2'($urandom % 3);
      takes <= takes + 1;
    end else if (stall != 2'd0) begin
      stall <= stall - 2'd1;
    end else if (vec_valid) begin
      vec_req <= 1'b1;
    end
  end
endmodule

// ===== tb/test_ext_irq_and_vector_map.sv
// test_ext_irq_and_vector_map.sv: self-checking bench for eivm_top
// assumes: eivm_core_model takes grants; registers reached over AHB-Lite
`timescale 1ns/100ps
`include "eivm_regs.svh"
module test_ext_irq_and_vector_map
  import eivm_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_irq_pin = 1, sleep_deep = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [7:0] pc_a = 0;
  logic [3:0] pc_b = 0;
  logic [5:0] pc_c = 0;
  logic [22:0] periph_irq = 0;
  wire logic [31:0] hrdata;
  wire logic [15:0] vec_addr, reset_vec_addr;
  wire logic [4:0] vec_num;
  wire logic hreadyout, hresp, vec_req, irq_pending, vec_valid, io_clk_run, wake_event;
  int error_cnt = 0, total_checks = 0, cycles = 0, takes;

  eivm_top i_eivm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_irq_pin),
    .pin_change_inputs_group_a(pc_a), .pin_change_inputs_group_b(pc_b),
    .pin_change_inputs_group_c(pc_c), .periph_irq(periph_irq), .sleep_deep(sleep_deep),
    .vec_req(vec_req), .irq_pending(irq_pending), .vec_addr(vec_addr),
    .vec_valid(vec_valid), .vec_num(vec_num), .io_clk_run(io_clk_run),
    .wake_event(wake_event), .reset_vec_addr(reset_vec_addr));
  eivm_core_model i_eivm_core_model (.hclk(hclk), .hresetn(hresetn),
    .vec_valid(vec_valid), .vec_req(vec_req), .takes(takes));

  always #25 hclk = ~hclk;

  task final_report;
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // expected word address of a vector number, from the map's base and spacing
  function automatic logic [31:0] exp_addr(input logic [4:0] n);
    return {16'h0000, `EIVM_VEC_RESET} + ({27'h0, n} - 32'h1) * {16'h0000, `EIVM_VEC_STEP};
  endfunction

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task settle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // bounded wait for a grant, sampled mid-cycle, then back onto a rising edge
  task grant(input logic [4:0] num);
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge hclk);
      if (vec_valid === 1'b1) break;
    end
    chk("vec_valid", vec_valid, 1);
    chk("vec_num", vec_num, num);
    chk("vec_addr", vec_addr, exp_addr(num));
    @(posedge hclk);
  endtask

  task flip(input int g, input int b);
    case (g)
      0: pc_a[b] <= ~pc_a[b];
      1: pc_b[b] <= ~pc_b[b];
      default: pc_c[b] <= ~pc_c[b];
    endcase
  endtask

  initial begin
    logic [31:0] m;
    int k, g, w, b, u;
    void'($urandom(32'ha3a4));
    settle(20);
    hresetn <= 1'b1;
    wr(32'h20, 32'hffffffff);
    for (k = 0; k <= 32'h20; k += 4) begin
      bus(1'b0, k, 0, rd);
      chk("reg", rd, 0);
      chk("hresp", hresp, 0);
    end
    chk("reset_vec", reset_vec_addr, 0);
    wr(`EIVM_OFS_CTRL, 32'h5);
    for (k = 0; k < 23; k++) begin
      periph_irq <= 23'(1 << k);
      grant(5'(k + 6));
      periph_irq <= 0;
      settle(6);
    end
    for (g = 0; g < 3; g++) begin
      w = (g == 0) ? 8 : (g == 1) ? 4 : 6;
      m = ($urandom % ((1 << w) - 1)) + 1;
      u = -1;
      for (k = 0; k < w; k++)
        if (m[k]) b = k;
        else u = k;
      wr(`EIVM_OFS_CTRL, 32'h1);
      wr(`EIVM_OFS_MASK_A + 4 * g, m);
      wr(`EIVM_OFS_ENABLE, 1 << (3 + g));
      if (u >= 0) flip(g, u);
      settle(6);
      bus(1'b0, `EIVM_OFS_FLAGS, 0, rd);
      chk("flags_unmasked", rd, 0);
      flip(g, b);
      @(negedge hclk);
      chk("wake_pc", wake_event, 1);
      settle(6);
      bus(1'b0, `EIVM_OFS_FLAGS, 0, rd);
      chk("flags_masked", rd, 1 << (3 + g));
      chk("vec_valid_off", vec_valid, 0);
      chk("pending_off", irq_pending, 0);
      wr(`EIVM_OFS_FLAGS, 1 << (3 + g));
      bus(1'b0, `EIVM_OFS_FLAGS, 0, rd);
      chk("flags_w1c", rd, 0);
      // flag and peripherals pending first, global enable last: all compete at once
      flip(g, b);
      periph_irq <= '1;
      settle(4);
      wr(`EIVM_OFS_CTRL, 32'h5);
      grant(5'(3 + g));
      periph_irq <= 0;
      settle(10);
      bus(1'b0, `EIVM_OFS_FLAGS, 0, rd);
      chk("flags_taken", rd, 0);
      wr(`EIVM_OFS_ENABLE, 0);
    end
    for (k = 0; k < 4; k++) begin
      ext_irq_pin <= (eivm_sense_t'(k) != eivm_sense_rise);
      settle(6);
      wr(`EIVM_OFS_FLAGS, 32'h40);
      wr(`EIVM_OFS_CTRL, 32'h4 | k);
      wr(`EIVM_OFS_ENABLE, 32'h40);
      settle(8);
      chk("ext_rest", vec_valid, 0);
      sleep_deep <= (k == 0);
      ext_irq_pin <= ~ext_irq_pin;
      @(negedge hclk);
      chk("clk_run", io_clk_run, k != 0);
      if (k == 0) chk("wake", wake_event, 1);
      @(posedge hclk);
      sleep_deep <= 1'b0;
      grant(5'd2);
      // low level stays held so the request must come back after the take
      if (k == 0) settle(12);
      if (k == 0) grant(5'd2);
      ext_irq_pin <= 1'b1;
      settle(10);
      wr(`EIVM_OFS_ENABLE, 0);
    end
    // three group grants and at least four ext grants are held by flag or level
    chk("takes", takes >= 7, 1);
    final_report();
  end
endmodule
